// ==== hw/ebcl_pkg.sv ====
package ebcl_pkg;
  // ==========================================================
  // Timing: serial clock half period from the system clock
  // ==========================================================
  localparam int CLK_NS      = 50;
  localparam int SK_HALF_NS  = 500;
  localparam int SK_HALF_CYC = (SK_HALF_NS + CLK_NS - 1) / CLK_NS;
  localparam logic [1:0] INIT_WAIT = 2'h3;  // Pin sync settle cycles
  // ==========================================================
  // Register byte offsets on the register bus
  // ==========================================================
  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_CFG  = 8'h04;
  localparam logic [7:0] OFF_BASE = 8'h08;
  localparam logic [7:0] OFF_STA0 = 8'h0c;
  localparam logic [7:0] OFF_STA1 = 8'h10;
  localparam logic [7:0] OFF_STA2 = 8'h14;
  localparam logic [7:0] OFF_PTR  = 8'h18;
  localparam logic [7:0] OFF_GP   = 8'h1c;
  localparam int CTRL_SEL    = 0;
  localparam int CTRL_RELOAD = 1;
  localparam int CTRL_STORE  = 2;
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // ==========================================================
  // Memory map and serial command set
  // ==========================================================
  localparam logic [2:0] STRAP_DEFAULT = 3'h7;
  localparam int         SLOT_SHIFT    = 2;
  localparam logic [5:0] STA_WORD      = 6'h20;
  localparam logic [1:0] OPC_READ      = 2'h2;
  localparam logic [1:0] OPC_WRITE     = 2'h1;
  localparam logic [1:0] OPC_EWEN      = 2'h0;
  localparam logic [5:0] EWEN_ADDR     = 6'h30;
  localparam logic [4:0] CMD_BITS      = 5'h09;
  localparam logic [4:0] RD_BITS       = 5'h1a;  // Cmd, dummy, 16 data
  localparam logic [4:0] WR_BITS       = 5'h19;  // Cmd and 16 data
  localparam logic [2:0] STEP_STA0     = 3'h2;
  localparam logic [2:0] LAST_LOAD     = 3'h4;
  localparam logic [2:0] LAST_STORE    = 3'h2;
  localparam logic [2:0] LAST_GPWR     = 3'h1;
  // Register reset values
  localparam logic [15:0] CFG_RST  = 16'h0000;
  localparam logic [15:0] BASE_RST = 16'h0000;
  localparam logic [47:0] STA_RST  = 48'h000000000000;
  // ==========================================================
  // Types
  // ==========================================================
  typedef enum logic [2:0] {
    S_IDLE, S_SETUP, S_SHIFT, S_CSLOW, S_POLL, S_FIN
  } ebcl_fsm_e;
  typedef enum logic [1:0] {J_LOAD, J_STORE, J_GPRD, J_GPWR} ebcl_job_e;
  typedef enum logic [1:0] {OP_EWEN, OP_READ, OP_WRITE} ebcl_op_e;
  typedef struct packed {
    logic cs;
    logic sk;
    logic di;
  } ebcl_pins_s;
  typedef struct packed {
    ebcl_fsm_e         fsm;
    ebcl_job_e         job;
    ebcl_op_e          op;
    logic [2:0]        step;
    logic [2:0]        last;
    logic [4:0]        div;
    logic              sk;
    logic              cs;
    logic              polled;
    logic [4:0]        bitcnt;
    logic [4:0]        nbits;
    logic [24:0]       tx;
    logic [15:0]       rx;
    logic [1:0]        init;
    logic              sel;
    logic [15:0]       cfg;
    logic [15:0]       base;
    logic [2:0][15:0]  sta;
    logic [5:0]        ptr;
    logic [15:0]       gp;
    logic              aw_got;
    logic [7:0]        awaddr;
    logic              w_got;
    logic [31:0]       wdata;
    logic [3:0]        wstrb;
    logic              bvalid;
    logic [1:0]        bresp;
    logic              rvalid;
    logic [31:0]       rdata;
    logic [1:0]        rresp;
  } ebcl_state_s;
endpackage : ebcl_pkg

// ==== hw/ebcl_loader.sv ====
// Implementation choices: the register addresses and the AXI4-Lite interface to the registers.
`timescale 1ns/1ns
// Summary of operation
// - Config at strap times 4, base next
// - Hardware reset loads setup words automatically
// - Station address always from words 20h-22h
// - Straps 7: station only, defaults elsewhere
// - All straps high selects fixed config and base defaults
// - 64x16 array, word addressed, whole words
// - Select 0 reload refreshes config, base, station
// - Select 0 store writes config and base
// - Control bits never stored nor loaded
// - Select 1 reload reads pointer word
// - Select 1 store writes general-purpose word
// - Reload, store read high while busy
// - Other registers locked while busy
// - Reset load is busy and locks too
// - No EEPROM pin: never access, keep defaults
module ebcl_loader
  import ebcl_pkg::*;
#(
  parameter logic [15:0] CFG_DEFAULT  = CFG_RST,
  parameter logic [15:0] BASE_DEFAULT = BASE_RST,
  parameter logic [47:0] STA_DEFAULT  = STA_RST
) (
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic        ce,
  input  wire logic [2:0]  config_slot_straps,
  input  wire logic        nvm_present_pin,
  input  wire logic        ee_do,
  output ebcl_pins_s       ee_pins,
  output logic [15:0]      cfg_out,
  output logic [15:0]      base_out,
  output logic [47:0]      station_out,
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready
);
  // ==========================================================
  // Pin synchronisers
  // ==========================================================
  logic [4:0]  pin_meta;  // First stage, read by second only
  logic [4:0]  pin_sync;  // Straps, present pin, serial data
  logic [2:0]  straps;    // Settled strap value
  logic        nvm_on;    // EEPROM fitted
  logic        do_in;     // Serial data from EEPROM

  // Two flops on every asynchronous pin
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pin_meta <= 5'h00;
      pin_sync <= 5'h00;
    end else if (ce) begin
      pin_meta <= {config_slot_straps, nvm_present_pin, ee_do};
      pin_sync <= pin_meta;
    end
  end
  assign straps = pin_sync[4:2];
  assign nvm_on = pin_sync[1];
  assign do_in  = pin_sync[0];

  // ==========================================================
  // Helper functions
  // ==========================================================
  // Byte-lane merge of a 16-bit register
  function automatic logic [15:0] merge16(input logic [15:0] old,
                                          input logic [31:0] wd,
                                          input logic [3:0]  st);
    merge16 = {st[1] ? wd[15:8] : old[15:8], st[0] ? wd[7:0] : old[7:0]};
  endfunction : merge16

  // Word address of the strap-chosen slot
  function automatic logic [5:0] slot_addr(input logic [2:0] s,
                                           input logic [2:0] k);
    slot_addr = 6'({s, 2'b00}) + 6'(k);
  endfunction : slot_addr

  // Opening of a job: first step, last step, defaults
  function automatic ebcl_state_s start_job(input ebcl_state_s s,
                                            input ebcl_job_e   j,
                                            input logic [2:0]  sp);
    start_job = s;
    start_job.job  = j;
    start_job.step = 3'h0;
    start_job.fsm  = S_SETUP;
    unique case (j)
      J_LOAD: begin
        start_job.last = LAST_LOAD;
        if (sp == STRAP_DEFAULT) begin
          start_job.step = STEP_STA0;
          start_job.cfg  = CFG_DEFAULT;
          start_job.base = BASE_DEFAULT;
        end
      end
      J_STORE: start_job.last = LAST_STORE;
      J_GPRD:  start_job.last = 3'h0;
      J_GPWR:  start_job.last = LAST_GPWR;
    endcase
  endfunction : start_job

  // ==========================================================
  // Main state: sequencer, registers, bus slave
  // ==========================================================
  ebcl_state_s r;      // Registered state
  ebcl_state_s n;      // Next state
  logic        busy;   // Any access running or pending
  logic [7:0]  wa;     // Aligned write address
  logic [7:0]  ra;     // Aligned read address
  logic [5:0]  waddr;  // Word address of the step
  logic [15:0] wword;  // Word to be written
  logic [1:0]  opc;    // Serial opcode of the step

  assign busy = (r.fsm != S_IDLE) || (r.init != 2'h0);

  // Next-state logic for everything
  always_comb begin
    n     = r;
    wa    = {r.awaddr[7:2], 2'b00};
    ra    = {s_axi_araddr[7:2], 2'b00};
    waddr = 6'h00;
    wword = 16'h0000;
    opc   = OPC_READ;
    // Address and data of the current step
    unique case (r.job)
      J_LOAD: begin
        if (r.step < STEP_STA0) waddr = slot_addr(straps, r.step);
        else waddr = STA_WORD + 6'(r.step - STEP_STA0);
      end
      J_STORE: begin
        waddr = slot_addr(straps, r.step - 3'h1);
        wword = (r.step == 3'h1) ? r.cfg : r.base;
      end
      J_GPRD, J_GPWR: begin
        waddr = r.ptr;
        wword = r.gp;
      end
    endcase

    unique case (r.fsm)
      // Idle: the serial lines rest low
      S_IDLE: begin
        n.cs = 1'b0;
        n.sk = 1'b0;
        if (r.init != 2'h0) begin
          n.init = r.init - 2'h1;
          if (r.init == 2'h1 && nvm_on) n = start_job(n, J_LOAD, straps);
        end
      end
      // Build the command word of one step
      S_SETUP: begin
        n.op = OP_READ;
        if ((r.job == J_STORE || r.job == J_GPWR) && r.step == 3'h0) begin
          n.op  = OP_EWEN;
          waddr = EWEN_ADDR;
        end else if (r.job == J_STORE || r.job == J_GPWR) begin
          n.op = OP_WRITE;
        end
        unique case (n.op)
          OP_EWEN:  opc = OPC_EWEN;
          OP_WRITE: opc = OPC_WRITE;
          default:  opc = OPC_READ;
        endcase
        n.tx     = {1'b1, opc, waddr, (n.op == OP_WRITE) ? wword : 16'h0};
        n.nbits  = (n.op == OP_READ) ? RD_BITS :
                   (n.op == OP_WRITE) ? WR_BITS : CMD_BITS;
        n.bitcnt = 5'h00;
        n.div    = 5'h00;
        n.polled = 1'b0;
        n.cs     = 1'b1;
        n.fsm    = S_SHIFT;
      end
      // Clock bits out on falling, sample on rising
      S_SHIFT: begin
        n.div = r.div + 5'h01;
        if (r.div == 5'(SK_HALF_CYC - 1)) begin
          n.div = 5'h00;
          if (!r.sk) begin
            n.sk     = 1'b1;
            n.bitcnt = r.bitcnt + 5'h01;
            if (r.bitcnt >= CMD_BITS) n.rx = {r.rx[14:0], do_in};
          end else begin
            n.sk = 1'b0;
            n.tx = {r.tx[23:0], 1'b0};
            if (r.bitcnt == r.nbits) n.fsm = S_CSLOW;
          end
        end
      end
      // Chip select low for one half period
      S_CSLOW: begin
        n.cs  = 1'b0;
        n.div = r.div + 5'h01;
        if (r.div == 5'(SK_HALF_CYC - 1)) begin
          n.div = 5'h00;
          if (r.op == OP_WRITE && !r.polled) begin
            n.cs     = 1'b1;
            n.polled = 1'b1;
            n.fsm    = S_POLL;
          end else begin
            n.fsm = S_FIN;
          end
        end
      end
      // wait for write-done ready
      // Ready trusted only after the sync flops see the selected line
      S_POLL: begin
        if (r.div < 5'(INIT_WAIT)) begin
          n.div = r.div + 5'h01;
        end else if (do_in) begin
          n.cs  = 1'b0;
          n.div = 5'h00;
          n.fsm = S_CSLOW;
        end
      end
      // Commit read data and advance
      S_FIN: begin
        if (r.op == OP_READ) begin
          if (r.job == J_GPRD) n.gp = r.rx;
          else if (r.step == 3'h0) n.cfg = r.rx;
          else if (r.step == 3'h1) n.base = r.rx;
          else n.sta[2'(r.step - STEP_STA0)] = r.rx;
        end
        if (r.step == r.last) begin
          n.fsm = S_IDLE;
        end else begin
          n.step = r.step + 3'h1;
          n.fsm  = S_SETUP;
        end
      end
      default: n.fsm = S_IDLE;
    endcase

    // Write address and data may come in either order
    if (s_axi_awvalid && s_axi_awready) begin
      n.aw_got = 1'b1;
      n.awaddr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      n.w_got = 1'b1;
      n.wdata = s_axi_wdata;
      n.wstrb = s_axi_wstrb;
    end
    if (r.bvalid && s_axi_bready) n.bvalid = 1'b0;
    // Execute a write once both halves are held
    if (r.aw_got && r.w_got && !r.bvalid) begin
      n.aw_got = 1'b0;
      n.w_got  = 1'b0;
      n.bvalid = 1'b1;
      n.bresp  = RESP_OKAY;
      if (wa == OFF_CTRL) begin
        // Control writes while busy are dropped quietly
        if (!busy && r.wstrb[0]) begin
          // only control bits, never in EEPROM
          n.sel = r.wdata[CTRL_SEL];
          if (nvm_on && r.wdata[CTRL_RELOAD])
            n = start_job(n, r.wdata[CTRL_SEL] ? J_GPRD : J_LOAD, straps);
          else if (nvm_on && r.wdata[CTRL_STORE])
            n = start_job(n, r.wdata[CTRL_SEL] ? J_GPWR : J_STORE, straps);
        end
      end else if (busy) begin
        n.bresp = RESP_SLVERR;
      end else begin
        unique case (wa)
          OFF_CFG:  n.cfg    = merge16(r.cfg, r.wdata, r.wstrb);
          OFF_BASE: n.base   = merge16(r.base, r.wdata, r.wstrb);
          OFF_STA0: n.sta[0] = merge16(r.sta[0], r.wdata, r.wstrb);
          OFF_STA1: n.sta[1] = merge16(r.sta[1], r.wdata, r.wstrb);
          OFF_STA2: n.sta[2] = merge16(r.sta[2], r.wdata, r.wstrb);
          OFF_PTR:  if (r.wstrb[0]) n.ptr = r.wdata[5:0];
          OFF_GP:   n.gp     = merge16(r.gp, r.wdata, r.wstrb);
          default:  n.bresp  = RESP_SLVERR;
        endcase
      end
    end

    // Read channel: one read under way at a time
    if (r.rvalid && s_axi_rready) n.rvalid = 1'b0;
    if (s_axi_arvalid && s_axi_arready) begin
      n.rvalid = 1'b1;
      n.rresp  = RESP_OKAY;
      n.rdata  = 32'h00000000;
      if (ra == OFF_CTRL) begin
        // both request bits high while busy
        n.rdata[CTRL_RELOAD] = busy;
        n.rdata[CTRL_STORE]  = busy;
        n.rdata[CTRL_SEL]    = r.sel;
      end else if (busy) begin
        n.rresp = RESP_SLVERR;
      end else begin
        unique case (ra)
          OFF_CFG:  n.rdata[15:0] = r.cfg;
          OFF_BASE: n.rdata[15:0] = r.base;
          OFF_STA0: n.rdata[15:0] = r.sta[0];
          OFF_STA1: n.rdata[15:0] = r.sta[1];
          OFF_STA2: n.rdata[15:0] = r.sta[2];
          OFF_PTR:  n.rdata[5:0]  = r.ptr;
          OFF_GP:   n.rdata[15:0] = r.gp;
          default:  n.rresp       = RESP_SLVERR;
        endcase
      end
    end
  end

  // Register the state; ce low freezes it
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      r      <= '0;
      r.init <= INIT_WAIT;
      r.cfg  <= CFG_DEFAULT;
      r.base <= BASE_DEFAULT;
      r.sta  <= STA_DEFAULT;
    end else if (ce) begin
      r <= n;
    end
  end

  // ==========================================================
  // Outputs
  // ==========================================================
  // Handshake readies are combinational on held state
  assign s_axi_awready = !r.aw_got && !r.bvalid;
  assign s_axi_wready  = !r.w_got && !r.bvalid;
  assign s_axi_arready = !r.rvalid;
  assign s_axi_bvalid  = r.bvalid;
  assign s_axi_bresp   = r.bresp;
  assign s_axi_rvalid  = r.rvalid;
  assign s_axi_rdata   = r.rdata;
  assign s_axi_rresp   = r.rresp;
  assign ee_pins.cs    = r.cs;
  assign ee_pins.sk    = r.sk;
  assign ee_pins.di    = r.cs & r.tx[24];
  assign cfg_out       = r.cfg;
  assign base_out      = r.base;
  assign station_out   = r.sta;
endmodule : ebcl_loader

// ==== sim/ebcl_eeprom_model.sv ====
`timescale 1ns/1ns
module ebcl_eeprom_model (
  input  wire logic cs,
  input  wire logic sk,
  input  wire logic di,
  input  wire logic slow,
  output logic      dout
);
  // ==========================================================
  // Storage and shift state
  // ==========================================================
  // 64 by 16 words
  logic [15:0] mem [64];
  logic [24:0] sr;    // Bits since start bit
  int          cnt;   // Clocks since start bit
  logic        rd;    // Read data phase
  logic        wen;   // Write enable latch
  logic        busy;  // Internal write cycle
  logic        pend;  // Ready status owed
  logic        dq;    // Last bit driven
  logic [15:0] dat;   // Read shift register
  initial begin
    {sr, cnt, rd, wen, busy, pend, dq, dat} = '0;
  end
  // Released line shows the inverse, never a stale copy
  assign dout = !cs ? ~dq : rd ? dq : (pend && cnt == 0) ? ~busy : ~dq;
  always @(negedge cs) begin
    cnt = 0;
    rd  = 1'b0;
  end
  always @(posedge sk) begin
    if (cs && (cnt > 0 || di)) begin
      cnt  = cnt + 1;
      sr   = {sr[23:0], di};
      pend = 1'b0;
      if (rd) begin
        dq  = dat[15];
        dat = {dat[14:0], 1'b0};
      end else if (cnt == 9) begin
        rd  = (sr[7:6] == 2'h2);
        dat = mem[sr[5:0]];
        dq  = 1'b0;
        if (sr[7:4] == 4'h3) wen = 1'b1;
      end else if (cnt == 25 && sr[23:22] == 2'h1 && wen) begin
        mem[sr[21:16]] = sr[15:0];
        busy = 1'b1;
        pend = 1'b1;
      end
    end
  end
  // Slow mode stretches the write cycle
  always @(posedge busy) begin
    #(slow ? 9000 : 700);
    busy = 1'b0;
  end
endmodule : ebcl_eeprom_model

// ==== sim/ebcl_loader_monitor.sv ====
`timescale 1ns/1ns
module ebcl_loader_monitor
  import ebcl_pkg::*;
(
  input wire logic        aclk,
  input wire logic        aresetn,
  input wire logic        nvm_present_pin,
  input wire ebcl_pins_s  ee_pins,
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic [1:0]  s_axi_bresp,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic [7:0]  s_axi_araddr,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0]  s_axi_rresp,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // ==========================================================
  // Memory fitted since reset
  // ==========================================================
  logic seen_reg;
  logic seen_next;
  always_comb seen_next = aresetn & (seen_reg | nvm_present_pin);
  always_ff @(posedge aclk) seen_reg <= seen_next;
  a_nvm_gate: assert property ($rose(ee_pins.cs) |-> seen_reg)
    else $error("select raised with no memory");
  a_sk_framed: assert property (ee_pins.sk |-> ee_pins.cs)
    else $error("serial clock outside frame");
  a_sk_half: assert property ($rose(ee_pins.sk) |-> ee_pins.sk [*8]
    ##1 ee_pins.sk ##1 ee_pins.sk ##1 !ee_pins.sk)
    else $error("serial clock high time wrong");
  a_di_fall: assert property ($changed(ee_pins.di) |->
    $fell(ee_pins.sk) || $changed(ee_pins.cs))
    else $error("data changed off falling clock");
  a_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready
    |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped");
  a_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready
    |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped");
  a_write_resp: assert property (s_axi_awvalid && s_axi_awready
    && s_axi_wvalid && s_axi_wready |-> ##2 s_axi_bvalid)
    else $error("write response late");
  a_read_resp: assert property (s_axi_arvalid && s_axi_arready
    |=> s_axi_rvalid)
    else $error("read response late");
  a_lock_err: assert property (s_axi_arvalid && s_axi_arready
    && ee_pins.cs && s_axi_araddr != OFF_CTRL
    |=> s_axi_rresp == RESP_SLVERR)
    else $error("register readable while busy");
  a_busy_bits: assert property (s_axi_arvalid && s_axi_arready
    && ee_pins.cs && s_axi_araddr == OFF_CTRL
    |=> s_axi_rdata[2:1] == 2'h3)
    else $error("request bits low while busy");
endmodule : ebcl_loader_monitor

bind ebcl_loader ebcl_loader_monitor ebcl_loader_monitor_i (
  .aclk, .aresetn, .nvm_present_pin, .ee_pins, .s_axi_awvalid,
  .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
  .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
  .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
  .s_axi_rready);

// ==== sim/ebcl_loader_tb_top.sv ====
`timescale 1ns/1ns
module ebcl_loader_tb_top;
  import ebcl_pkg::*;
  // ==========================================================
  // Bench signals
  // ==========================================================
  logic        aclk, aresetn, ce, nvm, slow, ee_do;
  logic [2:0]  straps;
  ebcl_pins_s  pins;
  logic [15:0] cfg_o, base_o;
  logic [47:0] sta_o;
  logic [7:0]  awaddr, araddr;
  logic [31:0] wdata, rdata;
  logic [3:0]  wstrb;
  logic [1:0]  bresp, rresp;
  logic        awvalid, awready, wvalid, wready, bvalid, bready;
  logic        arvalid, arready, rvalid, rready;
  logic [15:0] shadow [64];  // Expected memory image
  int          n_errors, total_checks;
  ebcl_loader ebcl_loader_i (.aclk(aclk), .aresetn(aresetn), .ce(ce),
    .config_slot_straps(straps), .nvm_present_pin(nvm), .ee_do(ee_do),
    .ee_pins(pins), .cfg_out(cfg_o), .base_out(base_o),
    .station_out(sta_o), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready));
  ebcl_eeprom_model ebcl_eeprom_model_i (.cs(pins.cs), .sk(pins.sk),
    .di(pins.di), .slow(slow), .dout(ee_do));
  initial begin
    aclk = 1'b0;
    forever #25 aclk = ~aclk;
  end
  // ==========================================================
  // Checking and bus tasks
  // ==========================================================
  task automatic wrap_up();
    $display("Checks %0d errors %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : wrap_up
  task automatic chk(input string nm, input logic [31:0] e, g);
    total_checks++;
    if (g !== e) begin
      n_errors++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  // A spent bound ends the run rather than hanging it
  task automatic tmo(input int n);
    if (n >= 4000) begin
      chk("wait bound", 0, n);
      wrap_up();
    end
  endtask : tmo
  task automatic wr(input logic [7:0] a, input logic [31:0] d,
                    input logic [1:0] er);
    int n;
    @(posedge aclk);
    awaddr  <= a;
    wdata   <= d;
    wstrb   <= 4'hf;
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    n = 0;
    do begin
      @(posedge aclk);
      n++;
      if (awready === 1'b1) awvalid <= 1'b0;
      if (wready === 1'b1) wvalid <= 1'b0;
    end while (bvalid !== 1'b1 && n < 4000);
    bready <= 1'b0;
    tmo(n);
    chk("bresp", 32'(er), 32'(bresp));
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [31:0] d,
                    output logic [1:0] r);
    int n;
    @(posedge aclk);
    araddr  <= a;
    arvalid <= 1'b1;
    rready  <= 1'b1;
    n = 0;
    do begin
      @(posedge aclk);
      n++;
      if (arready === 1'b1) arvalid <= 1'b0;
    end while (rvalid !== 1'b1 && n < 4000);
    d = rdata;
    r = rresp;
    rready <= 1'b0;
    tmo(n);
  endtask : rd
  task automatic rchk(input logic [7:0] a, input logic [31:0] e,
                      input logic [1:0] er);
    logic [31:0] d;
    logic [1:0]  r;
    rd(a, d, r);
    chk("rresp", 32'(er), 32'(r));
    if (er == RESP_OKAY) chk("rdata", e, d);
  endtask : rchk
  // Poll control until both request bits read low
  task automatic idle();
    logic [31:0] d;
    logic [1:0]  r;
    int          n;
    n = 0;
    do begin
      rd(OFF_CTRL, d, r);
      n++;
    end while (d[2:1] !== 2'h0 && n < 4000);
    tmo(n);
  endtask : idle
  task automatic rst(input logic [2:0] s, input logic p);
    @(posedge aclk);
    aresetn <= 1'b0;
    straps  <= s;
    nvm     <= p;
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
  endtask : rst
  // Expected setup word: strap slot, or defaults for strap 7
  function automatic logic [31:0] ecfg(logic [2:0] s, logic b);
    if (s == 3'h7) return {16'h0, b ? BASE_RST : CFG_RST};
    return {16'h0, shadow[{1'b0, s, 1'b0, b}]};
  endfunction : ecfg
  // ==========================================================
  // Main sequence
  // ==========================================================
  initial begin
    logic [31:0] v, w;
    logic [5:0]  p;
    logic [2:0]  s;
    {aresetn, nvm, slow, awvalid, wvalid, bready, arvalid, rready} = '0;
    {awaddr, araddr, wdata, wstrb, straps, n_errors, total_checks} = '0;
    ce = 1'b1;
    void'($urandom(32'h206327d3));
    for (int i = 0; i < 64; i++) begin
      shadow[i] = 16'($urandom);
      ebcl_eeprom_model_i.mem[i] = shadow[i];
    end
    for (int k = 0; k < 8; k++) begin
      s = 3'(k);
      rst(s, 1'b1);
      rchk(OFF_CFG, 0, RESP_SLVERR);
      idle();
      rchk(OFF_CFG, ecfg(s, 1'b0), RESP_OKAY);
      rchk(OFF_BASE, ecfg(s, 1'b1), RESP_OKAY);
      chk("cfg_out", ecfg(s, 1'b0), {16'h0, cfg_o});
      chk("base_out", ecfg(s, 1'b1), {16'h0, base_o});
      for (int j = 0; j < 3; j++) begin
        v = {16'h0, shadow[32 + j]};
        rchk(8'(OFF_STA0 + 4 * j), v, RESP_OKAY);
        chk("station_out", v, {16'h0, sta_o[16 * j +: 16]});
      end
    end
    s = 3'($urandom_range(6));
    rst(s, 1'b1);
    idle();
    v = $urandom;
    w = $urandom;
    wr(OFF_CFG, v, RESP_OKAY);
    wr(OFF_BASE, w, RESP_OKAY);
    wr(OFF_CTRL, 32'h4, RESP_OKAY);
    wr(OFF_BASE, 0, RESP_SLVERR);
    rchk(OFF_BASE, 0, RESP_SLVERR);
    idle();
    shadow[{1'b0, s, 2'h0}] = v[15:0];
    shadow[{1'b0, s, 2'h1}] = w[15:0];
    wr(OFF_CFG, 0, RESP_OKAY);
    wr(OFF_CTRL, 32'h2, RESP_OKAY);
    idle();
    rchk(OFF_CFG, ecfg(s, 1'b0), RESP_OKAY);
    rchk(OFF_BASE, ecfg(s, 1'b1), RESP_OKAY);
    for (int k = 0; k < 4; k++) begin
      v = $urandom;
      p = (k == 0) ? 6'h3f : v[21:16];
      // First pass always slow, so an early poll exit shows up
      slow <= (k == 0) | v[0];
      wr(OFF_PTR, {v[31:6], p}, RESP_OKAY);
      wr(OFF_GP, v, RESP_OKAY);
      wr(OFF_CTRL, 32'h5, RESP_OKAY);
      idle();
      shadow[p] = v[15:0];
      chk("stored", 32'(shadow[p]), 32'(ebcl_eeprom_model_i.mem[p]));
      chk("write done", 0, 32'(ebcl_eeprom_model_i.busy));
      p = p + 6'h5;
      wr(OFF_PTR, {26'h0, p}, RESP_OKAY);
      wr(OFF_CTRL, 32'h3, RESP_OKAY);
      idle();
      rchk(OFF_GP, {16'h0, shadow[p]}, RESP_OKAY);
      rchk(OFF_CTRL, 32'h1, RESP_OKAY);
    end
    rchk(8'h20, 0, RESP_SLVERR);
    wr(8'h24, v, RESP_SLVERR);
    rst(3'h0, 1'b0);
    idle();
    rchk(OFF_CFG, {16'h0, CFG_RST}, RESP_OKAY);
    rchk(OFF_STA0, {16'h0, STA_RST[15:0]}, RESP_OKAY);
    wr(OFF_CTRL, 32'h2, RESP_OKAY);
    rchk(OFF_CTRL, 0, RESP_OKAY);
    wrap_up();
  end
endmodule : ebcl_loader_tb_top
